// ==== hw/addr_decode.sv ====
/*
 * address decoder for the register block: names the target of an access.
 * assumes the address is already in the mclk domain.
 */
`default_nettype none
module addr_decode
	import bl_regs_pkg::*;
(
	input wire logic [bl_regs_pkg::ADDR_W-1:0] addr,
	output bl_regs_pkg::reg_sel_t sel,
	output logic [2:0] group_idx
);
	import bl_regs_pkg::*;

	always_comb begin
		sel = SEL_NONE;
		group_idx = 3'h0;
		case (addr)
			OFS_TEMP_LOW: sel = SEL_TEMP; // [RULE4]
			OFS_GROUP1: begin
				sel = SEL_GROUP; // [RULE8]
				group_idx = 3'h0;
			end
			OFS_GROUP2: begin
				sel = SEL_GROUP; // [RULE8]
				group_idx = 3'h1;
			end
			OFS_GROUP3: begin
				sel = SEL_GROUP; // [RULE9]
				group_idx = 3'h2;
			end
			OFS_GROUP4: begin
				sel = SEL_GROUP; // [RULE9]
				group_idx = 3'h3;
			end
			OFS_GROUP5: begin
				sel = SEL_GROUP; // [RULE10]
				group_idx = 3'h4;
			end
			OFS_COMMIT_CTRL: sel = SEL_COMMIT; // [RULE11]
			default: sel = SEL_NONE;
		endcase
	end
endmodule : addr_decode
`default_nettype wire

// ==== hw/bl_regs_pkg.sv ====
/*
 * shared constants and carriers for the group brightness / temperature floor register block.
 * assumes a simple synchronous register access port driven by the host interface logic.
 */
`default_nettype none
package bl_regs_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int GROUPS = 5;
	localparam int TEMP_W = 9;

	localparam logic [ADDR_W-1:0] OFS_TEMP_LOW = 9'h0_EE;
	localparam logic [ADDR_W-1:0] OFS_GROUP1 = 9'h1_3C;
	localparam logic [ADDR_W-1:0] OFS_GROUP2 = 9'h1_48;
	localparam logic [ADDR_W-1:0] OFS_GROUP3 = 9'h1_54;
	localparam logic [ADDR_W-1:0] OFS_GROUP4 = 9'h1_60;
	localparam logic [ADDR_W-1:0] OFS_GROUP5 = 9'h1_6C;
	localparam logic [ADDR_W-1:0] OFS_COMMIT_CTRL = 9'h1_78;

	localparam logic [TEMP_W-1:0] TEMP_LOW_RESET = 9'h0_69;
	localparam logic [DATA_W-1:0] DUTY_RESET = 16'hFFFF;
	localparam int COMMIT_BIT = 0;
	localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
	localparam logic [DATA_W-TEMP_W-1:0] TEMP_RSVD_ZERO = 7'h00;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic hit;
		logic [DATA_W-1:0] rdata;
	} reg_rsp_t;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_TEMP,
		SEL_GROUP,
		SEL_COMMIT
	} reg_sel_t;
endpackage : bl_regs_pkg
`default_nettype wire

// ==== hw/duty_group_slot.sv ====
/*
 * one double-buffered group duty slot: a shadow written by software and an active copy
 * loaded from it on commit. assumes write and commit strobes are single-cycle, same clock.
 */
`default_nettype none
module duty_group_slot #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic commit,
	output logic [WIDTH-1:0] shadow,
	output logic [WIDTH-1:0] active
);
	logic [WIDTH-1:0] shadow_r;
	logic [WIDTH-1:0] shadow_nxt;
	logic [WIDTH-1:0] active_r;
	logic [WIDTH-1:0] active_nxt;

	always_comb begin
		shadow_nxt = shadow_r;
		active_nxt = active_r;
		if (wr_en) begin
			shadow_nxt = wdata; // [RULE7]
		end
		// a write landing with commit goes straight through, so it is not lost for a frame
		if (commit) begin
			active_nxt = shadow_nxt; // [RULE11]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			shadow_r <= RESET_VAL; // [RULE6]
			active_r <= RESET_VAL;
		end else begin
			shadow_r <= shadow_nxt;
			active_r <= active_nxt;
		end
	end

	assign shadow = shadow_r;
	assign active = active_r;
endmodule : duty_group_slot
`default_nettype wire

// ==== hw/group_brightness_and_temp_floor_regs.sv ====
/*
 * register block of a backlight driver: five double-buffered group duty registers, the
 * commit strobe, and the signed lower junction-temperature limit.
 * assumes the host serial interface delivers one-cycle read/write requests on mclk.
 */
// Summary of operation
// RULE1: the low temperature limit is a 9-bit read/write signed field in bits 8..0.
// RULE2: codes 000h..0FFh of that field mean 0 to 255 degrees C.
// RULE3: codes 100h..1FFh of that field mean -256 to -1 degrees C.
// RULE4: the low limit register sits at offset EEh and resets to 69h.
// RULE5: bits 15..9 of the low limit register are reserved and read zero.
// RULE6: each group has a 16-bit read/write duty value resetting to FFFFh.
// RULE7: written duty values wait in a buffer until software writes the commit bit.
// RULE8: group 1 duty is at 13Ch and group 2 duty at 148h.
// RULE9: group 3 duty is at 154h and group 4 duty at 160h.
// RULE10: group 5 duty is at 16Ch.
// RULE11: writing one to bit 0 at 178h copies all buffered duty values to the active copies.
// RULE12: a duty read returns the last written buffered value, committed or not.
`default_nettype none
module group_brightness_and_temp_floor_regs
	import bl_regs_pkg::*;
#(
	parameter int N_GROUPS = bl_regs_pkg::GROUPS
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire bl_regs_pkg::reg_req_t req,
	output bl_regs_pkg::reg_rsp_t rsp,
	output logic [N_GROUPS*bl_regs_pkg::DATA_W-1:0] group_duty_active,
	output logic signed [bl_regs_pkg::TEMP_W-1:0] temp_low_limit,
	output logic brightness_commit
);
	import bl_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	reg_sel_t sel;
	logic [2:0] group_idx;
	logic commit_now;
	logic [DATA_W-1:0] shadow [N_GROUPS];
	logic [DATA_W-1:0] active [N_GROUPS];

	addr_decode u_decode (
		.addr(req.addr),
		.sel(sel),
		.group_idx(group_idx)
	);

	// commit bit is a self-clearing strobe; other control bits are not kept here
	assign commit_now = req.wr && (sel == SEL_COMMIT) && req.wdata[COMMIT_BIT]; // [RULE11]

	////////////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < N_GROUPS; g++) begin : g_slot
			duty_group_slot #(
				.WIDTH(DATA_W),
				.RESET_VAL(DUTY_RESET)
			) u_slot (
				.mclk(mclk),
				.reset_n(reset_n),
				.wr_en(req.wr && (sel == SEL_GROUP) && (group_idx == 3'(g))), // [RULE7]
				.wdata(req.wdata),
				.commit(commit_now),
				.shadow(shadow[g]),
				.active(active[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	logic [TEMP_W-1:0] temp_low_r;
	logic [TEMP_W-1:0] temp_low_nxt;

	always_comb begin
		temp_low_nxt = temp_low_r;
		if (req.wr && (sel == SEL_TEMP)) begin
			temp_low_nxt = req.wdata[TEMP_W-1:0]; // [RULE1]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			temp_low_r <= TEMP_LOW_RESET; // [RULE4]
		end else begin
			temp_low_r <= temp_low_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	reg_rsp_t rsp_r;
	reg_rsp_t rsp_nxt;

	always_comb begin
		rsp_nxt.valid = req.rd;
		rsp_nxt.hit = 1'b0;
		rsp_nxt.rdata = READ_ZERO;
		if (req.rd) begin
			case (sel)
				SEL_TEMP: begin
					rsp_nxt.hit = 1'b1;
					rsp_nxt.rdata = {TEMP_RSVD_ZERO, temp_low_r}; // [RULE5]
				end
				SEL_GROUP: begin
					rsp_nxt.hit = 1'b1;
					rsp_nxt.rdata = shadow[group_idx]; // [RULE12]
				end
				// commit bit never reads back as one since it does not persist
				SEL_COMMIT: rsp_nxt.hit = 1'b1;
				default: rsp_nxt.hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	assign rsp = rsp_r;

	////////////////////////////////////////////////////////////////////////////////
	logic [N_GROUPS*DATA_W-1:0] duty_out_r;
	logic [N_GROUPS*DATA_W-1:0] duty_out_nxt;
	logic signed [TEMP_W-1:0] temp_out_r;
	logic signed [TEMP_W-1:0] temp_out_nxt;
	logic commit_out_r;
	logic commit_out_nxt;

	// outputs are a registered copy, so the dimming engine sees a commit one cycle later
	always_comb begin
		for (int i = 0; i < N_GROUPS; i++) begin
			duty_out_nxt[i*DATA_W +: DATA_W] = active[i]; // [RULE6]
		end
		temp_out_nxt = $signed(temp_low_nxt); // [RULE2] [RULE3]
		commit_out_nxt = commit_now;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			duty_out_r <= {N_GROUPS{DUTY_RESET}};
			temp_out_r <= TEMP_LOW_RESET;
			commit_out_r <= 1'b0;
		end else begin
			duty_out_r <= duty_out_nxt;
			temp_out_r <= temp_out_nxt;
			commit_out_r <= commit_out_nxt;
		end
	end

	assign group_duty_active = duty_out_r;
	assign temp_low_limit = temp_out_r;
	assign brightness_commit = commit_out_r;
endmodule : group_brightness_and_temp_floor_regs
`default_nettype wire

// ==== verif/bl_regs_checker.sv ====
/* assertions on the ports of the group duty and low limit register block.
   assumes one clock, mclk, and the asynchronous active-low reset_n. */
`default_nettype none
module bl_regs_checker
	import bl_regs_pkg::*;
#(
	parameter int N_GROUPS = GROUPS
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire bl_regs_pkg::reg_req_t req,
	input wire bl_regs_pkg::reg_rsp_t rsp,
	input wire logic [N_GROUPS*DATA_W-1:0] group_duty_active,
	input wire logic signed [TEMP_W-1:0] temp_low_limit,
	input wire logic brightness_commit
);
	wire logic cw = req.wr && req.addr == OFS_COMMIT_CTRL && req.wdata[COMMIT_BIT];
	wire logic tw = req.wr && req.addr == OFS_TEMP_LOW;
	wire logic known = req.addr inside {OFS_TEMP_LOW, OFS_GROUP1, OFS_GROUP2, OFS_GROUP3,
		OFS_GROUP4, OFS_GROUP5, OFS_COMMIT_CTRL};
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_rd(a);
		req.rd && req.addr == a;
	endsequence
	sequence s_commit;
		cw ##1 brightness_commit;
	endsequence
	////////////////////////////////////////
	AST_RD_ANS: assert property (req.rd |=> rsp.valid) else $error("no answer");
	AST_NO_ANS: assert property (!req.rd |=> !rsp.valid) else $error("stray answer");
	AST_COMMIT: assert property (cw |-> s_commit) else $error("no commit pulse");
	AST_NO_COMMIT: assert property (!cw |=> !brightness_commit)
		else $error("stray commit");
	AST_HOLD: assert property (!brightness_commit |=> $stable(group_duty_active))
		else $error("duty moved without commit");
	AST_TEMP_WR: assert property (tw |=> temp_low_limit == $past(req.wdata[TEMP_W-1:0]))
		else $error("limit not loaded");
	AST_TEMP_KEEP: assert property (!tw |=> $stable(temp_low_limit))
		else $error("limit moved");
	AST_TEMP_RD: assert property (s_rd(OFS_TEMP_LOW) |=> rsp.hit &&
		rsp.rdata == {TEMP_RSVD_ZERO, $past(temp_low_limit)}) else $error("bad limit read");
	AST_UNMAPPED: assert property (req.rd && !known |=> !rsp.hit && rsp.rdata == READ_ZERO)
		else $error("unmapped read hit");
endmodule : bl_regs_checker
bind group_brightness_and_temp_floor_regs bl_regs_checker #(.N_GROUPS(N_GROUPS)) chk (.mclk,
	.reset_n, .req, .rsp, .group_duty_active, .temp_low_limit, .brightness_commit);
`default_nettype wire

// ==== verif/group_brightness_and_temp_floor_regs_tb.sv ====
/* self-checking bench for the group duty and low limit register block.
   assumes the package and design files are compiled before it. */
`default_nettype none
module group_brightness_and_temp_floor_regs_tb
	import bl_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0;
	logic reset_n = 0;
	reg_req_t req = '0;
	reg_rsp_t rsp;
	logic [79:0] act;
	logic signed [8:0] tl;
	logic bc;
	int bad_count = 0;
	int checks = 0;
	logic [16:0] expq[$];
	logic [31:0] lf = 32'h0000_2365;
	logic [15:0] dv[5];
	logic [8:0] ofs[5] = '{OFS_GROUP1, OFS_GROUP2, OFS_GROUP3, OFS_GROUP4, OFS_GROUP5};
	always #12.5 mclk = ~mclk;
	group_brightness_and_temp_floor_regs dut (.mclk, .reset_n, .req, .rsp,
		.group_duty_active(act), .temp_low_limit(tl), .brightness_commit(bc));
	////////////////////////////////////////
	function automatic logic [31:0] nx(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	task automatic cmp(logic [16:0] g, logic [16:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	// each request stands exactly one cycle, so calls run back to back
	task automatic acc(logic w, logic [8:0] a, logic [15:0] d, logic [16:0] e);
		@(posedge mclk);
		#2;
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		if (!w) expq.push_back(e);
	endtask : acc
	task automatic idle(int n);
		repeat (n) begin
			@(posedge mclk);
			#2;
			req = '0;
		end
	endtask : idle
	task automatic chk_act(bit done);
		for (int i = 0; i < 5; i++) cmp({1'b0, act[i*16+:16]}, {1'b0, done ? dv[i] : 16'hFFFF});
	endtask : chk_act
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	// x as the expectation: an answer nobody asked for always mismatches
	always @(posedge mclk) begin
		if (rsp.valid === 1'b1)
			cmp({rsp.hit, rsp.rdata}, expq.size() ? expq.pop_front() : 'x);
	end
	initial begin
		#100us;
		bad_count++;
		$display("CHECK FAILED %0t timeout", $time);
		summarize();
	end
	initial begin
		repeat (16) @(posedge mclk);
		#2;
		reset_n = 1;
		acc(0, OFS_TEMP_LOW, 0, 17'h1_0069);
		acc(0, OFS_COMMIT_CTRL, 0, 17'h1_0000);
		acc(0, 9'h0F0, 0, 17'h0_0000);
		for (int i = 0; i < 5; i++) acc(0, ofs[i], 0, 17'h1_FFFF);
		for (int i = 0; i < 5; i++) begin
			lf = nx(lf);
			dv[i] = lf[15:0];
			acc(1, ofs[i], dv[i], 0);
			acc(0, ofs[i], 0, {1'b1, dv[i]});
		end
		acc(1, 9'h0F0, 16'h1234, 0);
		acc(1, OFS_COMMIT_CTRL, 16'hFFFE, 0);
		idle(3);
		chk_act(0);
		acc(1, OFS_COMMIT_CTRL, 16'h0001, 0);
		idle(1);
		cmp({16'h0000, bc}, 17'h0_0001);
		idle(1);
		chk_act(1);
		acc(1, OFS_TEMP_LOW, 16'hFF80, 0);
		acc(0, OFS_TEMP_LOW, 0, 17'h1_0180);
		idle(1);
		cmp(17'(tl), 17'h1_FF80);
		acc(1, OFS_TEMP_LOW, 16'h00FF, 0);
		idle(2);
		cmp(17'(tl), 17'h0_00FF);
		for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge mclk);
		cmp(17'(expq.size()), 0);
		idle(1);
		reset_n = 0;
		idle(2);
		chk_act(0);
		cmp(17'(tl), 17'h0_0069);
		// second release: the group 1 buffered copy and the low limit must be back at their reset values too
		reset_n = 1;
		acc(0, OFS_GROUP1, 0, 17'h1_FFFF);
		acc(0, OFS_TEMP_LOW, 0, 17'h1_0069);
		idle(3);
		cmp(17'(expq.size()), 0);
		summarize();
	end
endmodule : group_brightness_and_temp_floor_regs_tb
`default_nettype wire
